/* hw/rmvs_pkg.sv */
// Package for the regulator mode and voltage select decision block.
// Assumes a single clock domain (hclk) and an AHB-Lite register slave.
package rmvs_pkg;

    // Register byte offsets
    localparam logic [7:0] RMVS_OFF_CTRL     = 8'h00;
    localparam logic [7:0] RMVS_OFF_ASSIGN   = 8'h04;
    localparam logic [7:0] RMVS_OFF_BUCKCFG  = 8'h08;
    localparam logic [7:0] RMVS_OFF_VSELCFG  = 8'h0c;
    localparam logic [7:0] RMVS_OFF_LDOMAP   = 8'h10;
    localparam logic [7:0] RMVS_OFF_STATUS   = 8'h14;
    localparam logic [7:0] RMVS_OFF_MODES    = 8'h18;
    localparam logic [7:0] RMVS_OFF_ASSIGNLD = 8'h1c;

    // Control register fields
    localparam int RMVS_CTRL_GATE_BIT = 0;
    localparam int RMVS_CTRL_INV_BIT  = 1;

    // Reset values
    localparam logic [31:0] RMVS_RST_CTRL    = 32'h0000_0000;
    localparam logic [31:0] RMVS_RST_BUCKCFG = 32'h0000_0000;
    localparam logic [31:0] RMVS_RST_VSELCFG = 32'h0000_0000;
    localparam logic [31:0] RMVS_RST_LDOMAP  = 32'h0000_00e4;

    // Converter operating modes, two bits each
    localparam logic [1:0] RMVS_MODE_OFF  = 2'h0;
    localparam logic [1:0] RMVS_MODE_ECO  = 2'h1;
    localparam logic [1:0] RMVS_MODE_AUTO = 2'h2;
    localparam logic [1:0] RMVS_MODE_PWM  = 2'h3;

    // Device power states seen by this block
    typedef enum logic [1:0] {
        RMVS_ST_OTHER,
        RMVS_ST_ACTIVE,
        RMVS_ST_SLEEP
    } rmvs_dev_state_type;

endpackage

/* hw/rmvs_top.sv */
// Regulator mode and voltage select decision logic with AHB-Lite registers.
// Assumes enable pins, strap and sleep pin are asynchronous to hclk.
`timescale 1ns/1ps
`default_nettype none
module rmvs_top
    import rmvs_pkg::*;
#(
    parameter int NBUCK = 4,
    parameter int NLDO  = 4,
    parameter int NPIN  = 4,
    parameter logic [31:0] OTP_ASSIGN = 32'h0000_0000
) (
    // Clock and reset
    input  wire logic                 hclk,
    input  wire logic                 hresetn,
    // AHB-Lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic      [31:0]          hrdata,
    output logic                      hreadyout,
    output logic                      hresp,
    // Device state and interrupt status from the sequencer
    input  wire logic                 dev_active,
    input  wire logic                 dev_sleep_now,
    input  wire logic                 irq_pending,
    // Pins
    input  wire logic                 pin_remap_strap,
    input  wire logic [NPIN-1:0]      external_enable_pin,
    input  wire logic                 power_request_pin,
    input  wire logic                 clock_request_pin_one,
    input  wire logic                 clock_request_pin_two,
    input  wire logic                 low_power_request_pin,
    // Regulator controls
    output logic                      sleep_request,
    output logic      [2*NBUCK-1:0]   buck_mode,
    output logic      [NBUCK-1:0]     buck_use_alternate,
    output logic      [NLDO-1:0]      ldo_use_alternate
);
    localparam int NREG = NBUCK + NLDO;

    // All state of the block
    typedef struct packed {
        logic [1:0]       s1_strap;
        logic [NPIN-1:0]  s1_en;
        logic [2:0]       s1_req;
        logic             s1_lp;
        logic [1:0]       s2_strap;
        logic [NPIN-1:0]  s2_en;
        logic [2:0]       s2_req;
        logic             s2_lp;
        logic             loaded;
        logic [31:0]      ctrl;
        logic [31:0]      assign_pend;
        logic [31:0]      assign_live;
        logic [31:0]      buckcfg;
        logic [31:0]      vselcfg;
        logic [31:0]      ldomap;
        logic             dp_wr;
        logic             dp_rd;
        logic [7:0]       dp_addr;
        logic [31:0]      rdata;
        logic             sleep_req;
        logic [2*NBUCK-1:0] mode;
        logic [NBUCK-1:0] buck_alt;
        logic [NLDO-1:0]  ldo_alt;
    } rmvs_state_type;

    rmvs_state_type st_q;
    rmvs_state_type st_d;

    // Decode scratch
    logic [NREG-1:0]  combined_pin;
    logic [NREG-1:0]  assigned;
    logic [NREG-1:0]  low_cond;
    logic [NREG-1:0]  alt_sel;
    logic [NPIN-1:0]  vsel_pin;
    logic [NPIN-1:0]  en_src;
    logic             strap_ao;
    logic             pins_live;
    logic             sleep_acc;
    logic             in_sleep;

    // Combinational view of synchronised pins; only second stage is read
    always_comb begin
        strap_ao  = st_q.s2_strap[0];
        vsel_pin  = st_q.s2_en;
        pins_live = dev_active | dev_sleep_now;
        sleep_acc = st_q.ctrl[RMVS_CTRL_GATE_BIT] & ~irq_pending
                    & (st_q.s2_lp ^ st_q.ctrl[RMVS_CTRL_INV_BIT]);
        in_sleep  = dev_sleep_now | st_q.sleep_req;
        // Strap low moves enabling onto the request pins; fourth unused
        en_src = strap_ao ? st_q.s2_en : {1'b0, st_q.s2_req};
    end

    // Per-regulator pin combination and voltage choice
    for (genvar r = 0; r < NREG; r++) begin : g_reg
        logic [NPIN-1:0] amask;
        logic [1:0]      map_idx;
        logic            pinsel;
        // Each pin has a NREG-bit assignment field; a regulator may sit in
        // several pins and a pin may serve many regulators
        for (genvar p = 0; p < NPIN; p++) begin : g_pin
            assign amask[p] = st_q.assign_live[p*NREG + r];
        end
        assign assigned[r]     = |amask;
        assign combined_pin[r] = |(amask & en_src) & pins_live;
        assign low_cond[r]     = assigned[r] ? ~combined_pin[r] : in_sleep;
        // Converters own their pin; linear regulators follow the map field
        if (r < NBUCK) begin : g_buck_idx
            assign map_idx = 2'(r);
        end else begin : g_ldo_idx
            assign map_idx = st_q.ldomap[2*(r-NBUCK) +: 2];
        end
        assign pinsel  = vsel_pin[map_idx];
        always_comb begin
            if (!strap_ao) begin
                alt_sel[r] = pinsel;
            end else if (!low_cond[r]) begin
                alt_sel[r] = st_q.vselcfg[r];
            end else begin
                alt_sel[r] = st_q.vselcfg[r] | st_q.vselcfg[8+r];
            end
        end
    end

    // Next-state process: sync chains, bus, decode
    always_comb begin
        logic [1:0] m;
        logic       en_b;
        logic       pwm;
        logic       ret;
        logic       shut;
        logic       eco;
        m    = RMVS_MODE_OFF;
        en_b = 1'b0;
        pwm  = 1'b0;
        ret  = 1'b0;
        shut = 1'b0;
        eco  = 1'b0;
        st_d = st_q;
        st_d.s1_strap = {1'b0, pin_remap_strap};
        st_d.s1_en    = external_enable_pin;
        st_d.s1_req   = {clock_request_pin_two, clock_request_pin_one, power_request_pin};
        st_d.s1_lp    = low_power_request_pin;
        st_d.s2_strap = st_q.s1_strap;
        st_d.s2_en    = st_q.s1_en;
        st_d.s2_req   = st_q.s1_req;
        st_d.s2_lp    = st_q.s1_lp;
        // OTP defaults load once; rewrites become live whenever the device is neither active nor asleep
        if (!st_q.loaded) begin
            st_d.loaded      = 1'b1;
            st_d.assign_pend = OTP_ASSIGN;
            st_d.assign_live = OTP_ASSIGN;
        end else if (!dev_active && !dev_sleep_now) begin
            st_d.assign_live = st_q.assign_pend;
        end
        // Data phase write
        if (st_q.dp_wr) begin
            case (st_q.dp_addr)
                RMVS_OFF_CTRL:    st_d.ctrl        = hwdata & 32'h0000_0003;
                RMVS_OFF_ASSIGN:  st_d.assign_pend = hwdata;
                RMVS_OFF_BUCKCFG: st_d.buckcfg     = hwdata;
                RMVS_OFF_VSELCFG: st_d.vselcfg     = hwdata;
                RMVS_OFF_LDOMAP:  st_d.ldomap      = hwdata & 32'h0000_00ff;
                default: ;
            endcase
        end
        // Address phase capture
        st_d.dp_wr   = hsel & hready & htrans[1] & hwrite;
        st_d.dp_rd   = hsel & hready & htrans[1] & ~hwrite;
        st_d.dp_addr = haddr[7:0];
        if (hsel && hready && htrans[1] && !hwrite) begin
            case (haddr[7:0])
                RMVS_OFF_CTRL:     st_d.rdata = st_q.ctrl;
                RMVS_OFF_ASSIGN:   st_d.rdata = st_q.assign_pend;
                RMVS_OFF_BUCKCFG:  st_d.rdata = st_q.buckcfg;
                RMVS_OFF_VSELCFG:  st_d.rdata = st_q.vselcfg;
                RMVS_OFF_LDOMAP:   st_d.rdata = st_q.ldomap;
                RMVS_OFF_STATUS:   st_d.rdata = {24'h0, 3'h0, st_q.s2_strap[0],
                                                 st_q.sleep_req, st_q.s2_lp,
                                                 pins_live, sleep_acc};
                RMVS_OFF_MODES:    st_d.rdata = {8'h0, 4'h0, st_q.ldo_alt,
                                                 4'h0, st_q.buck_alt, st_q.mode};
                RMVS_OFF_ASSIGNLD: st_d.rdata = st_q.assign_live;
                default:           st_d.rdata = 32'h0;
            endcase
        end
        st_d.sleep_req = sleep_acc;
        // Converter mode decode; buckcfg per converter byte:
        // bit0 enable, 1 force PWM, 2 retain, 3 shut, 4 light load
        for (int b = 0; b < NBUCK; b++) begin
            en_b = st_q.buckcfg[8*b];
            pwm  = st_q.buckcfg[8*b+1];
            ret  = st_q.buckcfg[8*b+2];
            shut = st_q.buckcfg[8*b+3];
            eco  = st_q.buckcfg[8*b+4];
            if (!en_b) begin
                m = RMVS_MODE_OFF;
            end else if (assigned[b]) begin
                if (combined_pin[b] || ret) begin
                    m = pwm ? RMVS_MODE_PWM : RMVS_MODE_AUTO;
                end else if (shut) begin
                    m = RMVS_MODE_OFF;
                end else begin
                    m = pwm ? RMVS_MODE_PWM : RMVS_MODE_ECO;
                end
            end else if (strap_ao && in_sleep && !ret) begin
                if (shut) begin
                    m = RMVS_MODE_OFF;
                end else begin
                    m = pwm ? RMVS_MODE_PWM : RMVS_MODE_ECO;
                end
            end else begin
                if (pwm) begin
                    m = RMVS_MODE_PWM;
                end else begin
                    m = eco ? RMVS_MODE_ECO : RMVS_MODE_AUTO;
                end
            end
            st_d.mode[2*b +: 2] = m;
        end
        st_d.buck_alt = alt_sel[NBUCK-1:0];
        st_d.ldo_alt  = alt_sel[NREG-1:NBUCK];
    end

    // State register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q         <= '0;
            st_q.ctrl    <= RMVS_RST_CTRL;
            st_q.buckcfg <= RMVS_RST_BUCKCFG;
            st_q.vselcfg <= RMVS_RST_VSELCFG;
            st_q.ldomap  <= RMVS_RST_LDOMAP;
        end else begin
            st_q <= st_d;
        end
    end

    // Outputs; slave always ready, always OKAY
    assign hreadyout          = 1'b1;
    assign hresp              = 1'b0;
    assign hrdata             = st_q.rdata;
    assign sleep_request      = st_q.sleep_req;
    assign buck_mode          = st_q.mode;
    assign buck_use_alternate = st_q.buck_alt;
    assign ldo_use_alternate  = st_q.ldo_alt;

    // Checks
    property p_off_when_disabled;
        @(posedge hclk) disable iff (!hresetn)
        !st_q.buckcfg[0] |=> buck_mode[1:0] == RMVS_MODE_OFF;
    endproperty
    a_off_when_disabled: assert property (p_off_when_disabled)
        else $error("disabled converter not off");

    property p_sleep_gate;
        @(posedge hclk) disable iff (!hresetn)
        (!st_q.ctrl[RMVS_CTRL_GATE_BIT] || irq_pending) |=> !sleep_request;
    endproperty
    a_sleep_gate: assert property (p_sleep_gate)
        else $error("sleep taken while gated");

    property p_low_power_pin_invert;
        @(posedge hclk) disable iff (!hresetn)
        (st_q.ctrl[RMVS_CTRL_GATE_BIT] && !irq_pending
         && (st_q.s2_lp != st_q.ctrl[RMVS_CTRL_INV_BIT])) |=> sleep_request;
    endproperty
    a_low_power_pin_invert: assert property (p_low_power_pin_invert)
        else $error("sleep polarity wrong");

    property p_strap_gnd_vsel;
        @(posedge hclk) disable iff (!hresetn)
        !st_q.s2_strap[0] |=> buck_use_alternate[0] == $past(st_q.s2_en[0]);
    endproperty
    a_strap_gnd_vsel: assert property (p_strap_gnd_vsel)
        else $error("select pin not followed");

    property p_active_sel;
        @(posedge hclk) disable iff (!hresetn)
        (st_q.s2_strap[0] && !low_cond[0]) |=> buck_use_alternate[0] == $past(st_q.vselcfg[0]);
    endproperty
    a_active_sel: assert property (p_active_sel)
        else $error("active select wrong");

    property p_sleep_sel;
        @(posedge hclk) disable iff (!hresetn)
        (st_q.s2_strap[0] && low_cond[0] && st_q.vselcfg[8]) |=> buck_use_alternate[0];
    endproperty
    a_sleep_sel: assert property (p_sleep_sel)
        else $error("sleep select wrong");

    property p_assigned_high;
        @(posedge hclk) disable iff (!hresetn)
        (st_q.buckcfg[0] && assigned[0] && combined_pin[0] && !st_q.buckcfg[1])
        |=> buck_mode[1:0] == RMVS_MODE_AUTO;
    endproperty
    a_assigned_high: assert property (p_assigned_high)
        else $error("assigned high not auto");

    property p_assigned_shut;
        @(posedge hclk) disable iff (!hresetn)
        (st_q.buckcfg[0] && assigned[0] && !combined_pin[0]
         && !st_q.buckcfg[2] && st_q.buckcfg[3]) |=> buck_mode[1:0] == RMVS_MODE_OFF;
    endproperty
    a_assigned_shut: assert property (p_assigned_shut)
        else $error("assigned low shut not off");

    property p_pins_dead;
        @(posedge hclk) disable iff (!hresetn)
        (!dev_active && !dev_sleep_now) |-> combined_pin == '0;
    endproperty
    a_pins_dead: assert property (p_pins_dead)
        else $error("pins live outside active or sleep");

    property p_unassigned_pwm;
        @(posedge hclk) disable iff (!hresetn)
        (st_q.buckcfg[0] && st_q.buckcfg[1] && !assigned[0] && !in_sleep)
        |=> buck_mode[1:0] == RMVS_MODE_PWM;
    endproperty
    a_unassigned_pwm: assert property (p_unassigned_pwm)
        else $error("unassigned forced PWM not taken");

    property p_sleep_shut_off;
        @(posedge hclk) disable iff (!hresetn)
        (st_q.buckcfg[0] && !assigned[0] && strap_ao && in_sleep
         && !st_q.buckcfg[2] && st_q.buckcfg[3]) |=> buck_mode[1:0] == RMVS_MODE_OFF;
    endproperty
    a_sleep_shut_off: assert property (p_sleep_shut_off)
        else $error("unassigned sleep shut not off");

    property p_remap_source;
        @(posedge hclk) disable iff (!hresetn)
        (!strap_ao && pins_live && st_q.assign_live[0] && st_q.s2_req[0]) |-> combined_pin[0];
    endproperty
    a_remap_source: assert property (p_remap_source)
        else $error("request pin does not enable");

    property p_ldo_map;
        @(posedge hclk) disable iff (!hresetn)
        !strap_ao |=> ldo_use_alternate[0] == $past(vsel_pin[st_q.ldomap[1:0]]);
    endproperty
    a_ldo_map: assert property (p_ldo_map)
        else $error("linear select pin map wrong");

    c_sleep: cover property (@(posedge hclk) disable iff (!hresetn) $rose(sleep_request));
    c_pwm: cover property (@(posedge hclk) disable iff (!hresetn)
        buck_mode[1:0] == RMVS_MODE_PWM);
    c_alt: cover property (@(posedge hclk) disable iff (!hresetn) ldo_use_alternate[0]);
    c_remap: cover property (@(posedge hclk) disable iff (!hresetn)
        !strap_ao && (st_q.s2_req != 3'h0));
endmodule
`default_nettype wire

/* dv/rmvs_host_model.sv */
// Host model: drives the enable, strap and sleep pins of the block.
// Assumes the bench gives wanted levels; pins move just after hclk.
`timescale 1ns/1ps
`default_nettype none
module rmvs_host_model (
    // Clock
    input  wire logic       hclk,
    // Wanted levels from the bench
    input  wire logic       strap_lvl,
    input  wire logic [3:0] en_lvl,
    input  wire logic       want_sleep,
    input  wire logic       invert,
    input  wire logic       irq_pending,
    input  wire logic       rude,
    input  wire logic [2:0] req_lvl,
    // Pins
    output var logic        pin_remap_strap,
    output var logic [3:0]  external_enable_pin,
    output var logic        power_request_pin,
    output var logic        clock_request_pin_one,
    output var logic        clock_request_pin_two,
    output var logic        low_power_request_pin
);
    // Pins start quiet with the strap at the always-on rail
    initial begin
        pin_remap_strap = 1'b1;
        external_enable_pin = 4'h0;
        power_request_pin = 1'b0;
        clock_request_pin_one = 1'b0;
        clock_request_pin_two = 1'b0;
        low_power_request_pin = 1'b0;
    end

    // A polite host keeps the sleep pin idle while an interrupt waits
    always @(posedge hclk) begin
        pin_remap_strap <= strap_lvl;
        external_enable_pin <= en_lvl;
        {clock_request_pin_two, clock_request_pin_one, power_request_pin} <= req_lvl;
        low_power_request_pin <= (want_sleep && (!irq_pending || rude)) ^ invert;
    end
endmodule
`default_nettype wire

/* dv/tb_top.sv */
// Self-checking bench for the regulator mode and voltage select block.
// Assumes rmvs_pkg, rmvs_top and the host model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import rmvs_pkg::*;
    localparam logic [31:0] OTP_ASGN = 32'h8000_0000;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic        dev_active = 1'b0;
    logic        dev_sleep_now = 1'b0;
    logic        irq_pending = 1'b0;
    logic        strap_lvl = 1'b1;
    logic [3:0]  en_lvl = 4'h0;
    logic        want_sleep = 1'b0;
    logic        inv = 1'b0;
    logic        rude = 1'b0;
    logic [2:0]  req_lvl = 3'h0;
    wire logic [31:0] hrdata;
    wire logic        hreadyout;
    wire logic        hresp;
    wire logic [2:0]  req_pin;
    wire logic        strap;
    wire logic [3:0]  en_pin;
    wire logic        lp_pin;
    wire logic        sleep_request;
    wire logic [7:0]  buck_mode;
    wire logic [3:0]  buck_alt;
    wire logic [3:0]  ldo_alt;
    int mismatches = 0;
    int checks_done = 0;

    // 125 MHz clock
    always #4 hclk = ~hclk;

    rmvs_host_model host (.hclk(hclk), .strap_lvl(strap_lvl), .en_lvl(en_lvl),
        .want_sleep(want_sleep), .invert(inv), .irq_pending(irq_pending), .rude(rude),
        .req_lvl(req_lvl), .power_request_pin(req_pin[0]),
        .clock_request_pin_one(req_pin[1]), .clock_request_pin_two(req_pin[2]),
        .pin_remap_strap(strap), .external_enable_pin(en_pin), .low_power_request_pin(lp_pin));

    rmvs_top #(.OTP_ASSIGN(OTP_ASGN)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .dev_active(dev_active), .dev_sleep_now(dev_sleep_now), .irq_pending(irq_pending),
        .pin_remap_strap(strap), .external_enable_pin(en_pin), .power_request_pin(req_pin[0]),
        .clock_request_pin_one(req_pin[1]), .clock_request_pin_two(req_pin[2]),
        .low_power_request_pin(lp_pin), .sleep_request(sleep_request), .buck_mode(buck_mode),
        .buck_use_alternate(buck_alt), .ldo_use_alternate(ldo_alt));

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Bounded wait for hready sampled high at a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 16) begin
                mismatches++;
                $display("CHECK FAILED hready expected 1 seen %b", hreadyout);
                wrap_up();
            end
            @(posedge hclk);
        end
    endtask

    // One single-word transfer: address phase, then data phase
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= wr;
        wait_ready();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wait_ready();
        q = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        ahb(1'b1, a, d, q);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        ahb(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask

    // Host model edge, two sync edges, decode edge, plus one spare
    task automatic settle();
        repeat (5) @(posedge hclk);
    endtask

    task automatic t_regs();
        rd_chk("ctrl", RMVS_OFF_CTRL, RMVS_RST_CTRL);
        rd_chk("buckcfg", RMVS_OFF_BUCKCFG, RMVS_RST_BUCKCFG);
        rd_chk("vselcfg", RMVS_OFF_VSELCFG, RMVS_RST_VSELCFG);
        rd_chk("ldomap", RMVS_OFF_LDOMAP, RMVS_RST_LDOMAP);
        rd_chk("live assign", RMVS_OFF_ASSIGNLD, OTP_ASGN);
        rd_chk("unmapped", 8'h40, 32'h0);
        wr(8'h40, 32'hffff_ffff);
        rd_chk("buckcfg kept", RMVS_OFF_BUCKCFG, RMVS_RST_BUCKCFG);
        $display("test regs done");
    endtask

    // Unassigned converters in ACTIVE, then in SLEEP
    task automatic t_unassigned();
        dev_active <= 1'b1;
        wr(RMVS_OFF_BUCKCFG, 32'h0201_1103);
        settle();
        chk("modes active", 32'h27, {24'h0, buck_mode});
        dev_active <= 1'b0;
        dev_sleep_now <= 1'b1;
        wr(RMVS_OFF_BUCKCFG, 32'h1503_0109);
        settle();
        chk("modes sleep", 32'h74, {24'h0, buck_mode});
        $display("test unassigned done");
    endtask

    // Voltage choice by state, then by select pins with the strap low
    task automatic t_voltage();
        dev_active <= 1'b1;
        dev_sleep_now <= 1'b0;
        wr(RMVS_OFF_VSELCFG, 32'h0000_6215);
        settle();
        chk("buck alt active", 32'h5, {28'h0, buck_alt});
        chk("ldo alt active", 32'h1, {28'h0, ldo_alt});
        dev_active <= 1'b0;
        dev_sleep_now <= 1'b1;
        settle();
        chk("buck alt sleep", 32'h7, {28'h0, buck_alt});
        chk("ldo alt sleep", 32'h7, {28'h0, ldo_alt});
        strap_lvl <= 1'b0;
        en_lvl <= 4'b0011;
        wr(RMVS_OFF_LDOMAP, 32'h0000_001b);
        settle();
        chk("buck alt pins", 32'h3, {28'h0, buck_alt});
        chk("ldo alt pins", 32'hc, {28'h0, ldo_alt});
        strap_lvl <= 1'b1;
        en_lvl <= 4'h0;
        $display("test voltage done");
    endtask

    // Converters on shared and multiple enable pins
    task automatic t_assigned();
        dev_sleep_now <= 1'b0;
        wr(RMVS_OFF_ASSIGN, 32'h8000_0203);
        settle();
        rd_chk("live assign new", RMVS_OFF_ASSIGNLD, 32'h8000_0203);
        dev_active <= 1'b1;
        wr(RMVS_OFF_BUCKCFG, 32'h0705_0109);
        settle();
        chk("pins low", 32'he4, {24'h0, buck_mode});
        en_lvl <= 4'b0010;
        settle();
        chk("pin one high", 32'he8, {24'h0, buck_mode});
        en_lvl <= 4'b0001;
        dev_active <= 1'b0;
        dev_sleep_now <= 1'b1;
        settle();
        chk("pin zero high", 32'hea, {24'h0, buck_mode});
        rd_chk("modes reg", RMVS_OFF_MODES, 32'h0007_05ea);
        dev_sleep_now <= 1'b0;
        settle();
        chk("pins outside states", 32'he4, {24'h0, buck_mode});
        $display("test assigned done");
    endtask

    // Strap low: request pins enable, enable pins only pick voltage
    task automatic t_remap();
        dev_active <= 1'b1;
        strap_lvl <= 1'b0;
        en_lvl <= 4'b0011;
        req_lvl <= 3'b000;
        settle();
        chk("remap none", 32'he4, {24'h0, buck_mode});
        req_lvl <= 3'b001;
        settle();
        chk("remap power", 32'hea, {24'h0, buck_mode});
        req_lvl <= 3'b010;
        settle();
        chk("remap clock one", 32'he8, {24'h0, buck_mode});
        strap_lvl <= 1'b1;
        req_lvl <= 3'b000;
        en_lvl <= 4'h0;
        $display("test remap done");
    endtask

    // Sleep pin gating, interrupt block and polarity; entries {inv,gate,irq,rude,exp}
    task automatic t_sleep();
        logic [4:0] tab [4];
        tab = '{5'b00000, 5'b01110, 5'b01001, 5'b11001};
        dev_sleep_now <= 1'b0;
        dev_active <= 1'b1;
        en_lvl <= 4'h0;
        want_sleep <= 1'b1;
        wr(RMVS_OFF_BUCKCFG, 32'h0009_0000);
        for (int i = 0; i < 4; i++) begin
            inv <= tab[i][4];
            irq_pending <= tab[i][2];
            rude <= tab[i][1];
            wr(RMVS_OFF_CTRL, {30'h0, tab[i][4], tab[i][3]});
            settle();
            chk("sleep request", {31'h0, tab[i][0]}, {31'h0, sleep_request});
            chk("buck2 mode", {30'h0, tab[i][0] ? RMVS_MODE_OFF : RMVS_MODE_AUTO},
                {30'h0, buck_mode[5:4]});
        end
        rd_chk("status", RMVS_OFF_STATUS, 32'h0000_001b);
        $display("test sleep done");
    endtask

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_unassigned();
        t_voltage();
        t_assigned();
        t_remap();
        t_sleep();
        wrap_up();
    end
endmodule
`default_nettype wire
